/* hw/scsm_pkg.sv */
package scsm_pkg;
   // timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int RC_PERIOD_NS = 125;
   // longest time: rounds down
   localparam int RC_DIV_CYC = RC_PERIOD_NS / CLK_PERIOD_NS;
   localparam int MON_TIMEOUT_NS = 1000;
   // least time: rounds up
   localparam int MON_TIMEOUT_CYC = (MON_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // widths
   localparam int AW = 8;
   localparam int DW = 32;
   localparam int DIVW = 4;
   localparam int CNTW = 8;
   // register offsets
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_PRESC = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h0c;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
   // fields
   localparam int CTRL_SRC_LSB = 0;
   localparam int CTRL_PLL_EXT_BIT = 2;
   localparam int PRESC_SYS_LSB = 0;
   localparam int PRESC_FAST_LSB = 4;
   localparam int PRESC_SLOW_LSB = 8;
   localparam int STATUS_PLL_LOCK_BIT = 2;
   localparam int IRQ_CSS_BIT = 0;
   localparam int IRQ_PLL_BIT = 1;
   // reset values
   localparam logic [DW-1:0] CTRL_RST = 32'h0000_0000;
   localparam logic [DW-1:0] PRESC_RST = 32'h0000_0100;
   localparam logic [1:0] MASK_RST = 2'h0;

   typedef enum logic [1:0] {
      SCSM_SRC_RC,
      SCSM_SRC_EXT,
      SCSM_SRC_PLL
   } scsm_src_t;
endpackage : scsm_pkg

/* hw/scsm_prescaler.sv */
`timescale 1ns/10ps
`default_nettype none
module scsm_prescaler (
   input wire logic clk_sys, // system clock
   input wire logic reset_n, // sync reset
   input wire logic tick_in, // input rate enable
   input wire logic [scsm_pkg::DIVW-1:0] div, // divide by div+1
   output logic tick_out // output rate enable
);
   import scsm_pkg::*;

   logic [DIVW-1:0] cnt_reg;
   logic [DIVW-1:0] cnt_next;
   logic tick_reg;
   logic tick_next;

   always_comb begin
      cnt_next = cnt_reg;
      tick_next = 1'b0;
      if (tick_in) begin
         if (cnt_reg >= div) begin
            cnt_next = '0;
            tick_next = 1'b1;
         end else begin
            cnt_next = cnt_reg + 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         cnt_reg <= '0;
         tick_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         tick_reg <= tick_next;
      end
   end

   assign tick_out = tick_reg;
endmodule : scsm_prescaler
`default_nettype wire

/* hw/scsm_clk_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module scsm_clk_monitor (
   input wire logic clk_sys, // system clock
   input wire logic reset_n, // sync reset
   input wire logic watch_en, // supervise now
   input wire logic ext_clk_in, // sampled external clock level
   output logic ext_edge, // rising edge seen, pulse
   output logic fail // no edge within timeout, pulse
);
   import scsm_pkg::*;

   logic level_reg;
   logic edge_reg;
   logic edge_next;
   logic fail_reg;
   logic fail_next;
   logic [CNTW-1:0] cnt_reg;
   logic [CNTW-1:0] cnt_next;

   always_comb begin
      edge_next = ext_clk_in && !level_reg;
      fail_next = 1'b0;
      cnt_next = '0;
      if (watch_en && !edge_next) begin
         if (cnt_reg == CNTW'(MON_TIMEOUT_CYC - 1)) begin
            // restart so a dead clock keeps reporting
            fail_next = 1'b1;
         end else begin
            cnt_next = cnt_reg + 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         level_reg <= 1'b0;
         edge_reg <= 1'b0;
         fail_reg <= 1'b0;
         cnt_reg <= '0;
      end else begin
         level_reg <= ext_clk_in;
         edge_reg <= edge_next;
         fail_reg <= fail_next;
         cnt_reg <= cnt_next;
      end
   end

   assign ext_edge = edge_reg;
   assign fail = fail_reg;
endmodule : scsm_clk_monitor
`default_nettype wire

/* hw/scsm_top.sv */
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module scsm_top (
   input wire logic clk_sys, // system clock, 100 MHz
   input wire logic reset_n, // sync reset, active low
   input wire logic [scsm_pkg::AW-1:0] reg_addr, // register byte address
   input wire logic [scsm_pkg::DW-1:0] reg_wdata, // write data
   input wire logic reg_wr, // write strobe
   input wire logic reg_rd, // read strobe
   output logic [scsm_pkg::DW-1:0] reg_rdata, // read data, cycle after strobe
   input wire logic ext_clk_in, // external oscillator level, sampled
   input wire logic pll_clk_tick, // loop output rate enable
   input wire logic pll_lock, // loop locked
   output logic irq, // level interrupt
   output var scsm_pkg::scsm_src_t active_src, // current system source
   output logic sys_bus_tick, // system bus rate enable
   output logic fast_bus_tick, // fast peripheral bus rate enable
   output logic slow_bus_tick // slow peripheral bus rate enable
);
   import scsm_pkg::*;

   scsm_src_t src_reg;
   scsm_src_t src_next;
   logic [DW-1:0] ctrl_reg;
   logic [DW-1:0] ctrl_next;
   logic [DW-1:0] presc_reg;
   logic [DW-1:0] presc_next;
   logic [1:0] mask_reg;
   logic [1:0] mask_next;
   logic [1:0] stat_reg;
   logic [1:0] stat_next;
   logic [DW-1:0] rdata_reg;
   logic [DW-1:0] rdata_next;
   logic irq_reg;
   logic irq_next;
   logic [CNTW-1:0] rc_cnt_reg;
   logic [CNTW-1:0] rc_cnt_next;
   logic rc_tick_reg;
   logic rc_tick_next;
   logic root_tick_reg;
   logic root_tick_next;

   logic mon_en;
   logic mon_edge;
   logic mon_fail;
   logic css_evt;
   logic pll_fail_evt;
   logic wr_ctrl;
   logic wr_stat;
   scsm_src_t req_src;

   function automatic scsm_src_t decode_src(input logic [1:0] code);
      scsm_src_t s;
      s = SCSM_SRC_RC;
      if (code == 2'(SCSM_SRC_EXT)) begin
         s = SCSM_SRC_EXT;
      end else if (code == 2'(SCSM_SRC_PLL)) begin
         s = SCSM_SRC_PLL;
      end
      return s;
   endfunction : decode_src

   assign wr_ctrl = reg_wr && (reg_addr == ADDR_CTRL);
   assign wr_stat = reg_wr && (reg_addr == ADDR_IRQ_STAT);
   assign req_src = decode_src(reg_wdata[CTRL_SRC_LSB +: 2]);

   // the loop fed from the external oscillator needs the same watch
   assign mon_en = (src_reg == SCSM_SRC_EXT) ||
                   ((src_reg == SCSM_SRC_PLL) && ctrl_reg[CTRL_PLL_EXT_BIT]);
   assign css_evt = mon_fail && mon_en;
   assign pll_fail_evt = (src_reg == SCSM_SRC_PLL) &&
                         (!pll_lock || (css_evt && ctrl_reg[CTRL_PLL_EXT_BIT]));

   scsm_clk_monitor u_monitor (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .watch_en(mon_en),
      .ext_clk_in(ext_clk_in),
      .ext_edge(mon_edge),
      .fail(mon_fail)
   );

   // internal RC rate, approximated from the system clock
   always_comb begin
      rc_tick_next = 1'b0;
      rc_cnt_next = rc_cnt_reg + 1'b1;
      if (rc_cnt_reg == CNTW'(RC_DIV_CYC - 1)) begin
         rc_cnt_next = '0;
         rc_tick_next = 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         rc_cnt_reg <= '0;
         rc_tick_reg <= 1'b0;
      end else begin
         rc_cnt_reg <= rc_cnt_next;
         rc_tick_reg <= rc_tick_next;
      end
   end

   // source selection; a fallback beats a software write in the same cycle
   always_comb begin
      src_next = src_reg;
      if (wr_ctrl) begin
         src_next = req_src;
      end
      if (css_evt || pll_fail_evt) begin
         src_next = SCSM_SRC_RC;
      end
      case (src_reg)
         SCSM_SRC_RC: root_tick_next = rc_tick_reg;
         SCSM_SRC_EXT: root_tick_next = mon_edge;
         SCSM_SRC_PLL: root_tick_next = pll_clk_tick;
         default: root_tick_next = rc_tick_reg;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         src_reg <= SCSM_SRC_RC;
         root_tick_reg <= 1'b0;
      end else begin
         src_reg <= src_next;
         root_tick_reg <= root_tick_next;
      end
   end

   // single root feeds one chain: system bus, then both peripheral buses
   scsm_prescaler u_sys_presc (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .tick_in(root_tick_reg),
      .div(presc_reg[PRESC_SYS_LSB +: DIVW]),
      .tick_out(sys_bus_tick)
   );

   scsm_prescaler u_fast_presc (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .tick_in(sys_bus_tick),
      .div(presc_reg[PRESC_FAST_LSB +: DIVW]),
      .tick_out(fast_bus_tick)
   );

   scsm_prescaler u_slow_presc (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .tick_in(sys_bus_tick),
      .div(presc_reg[PRESC_SLOW_LSB +: DIVW]),
      .tick_out(slow_bus_tick)
   );

   // registers, status and interrupt
   always_comb begin
      ctrl_next = ctrl_reg;
      presc_next = presc_reg;
      mask_next = mask_reg;
      rdata_next = '0;
      if (wr_ctrl) begin
         ctrl_next = reg_wdata;
      end
      // ratios are not checked: bus ceilings are software's job
      if (reg_wr && (reg_addr == ADDR_PRESC)) begin
         presc_next = reg_wdata;
      end
      if (reg_wr && (reg_addr == ADDR_IRQ_MASK)) begin
         mask_next = reg_wdata[1:0];
      end
      // write one to clear; a new event in the same cycle wins
      stat_next = stat_reg & ~(wr_stat ? reg_wdata[1:0] : 2'h0);
      if (css_evt) begin
         stat_next[IRQ_CSS_BIT] = 1'b1;
      end
      if (pll_fail_evt) begin
         stat_next[IRQ_PLL_BIT] = 1'b1;
      end
      irq_next = |(stat_reg & mask_reg);
      if (reg_rd) begin
         case (reg_addr)
            ADDR_CTRL: rdata_next = ctrl_reg;
            ADDR_PRESC: rdata_next = presc_reg;
            ADDR_STATUS: begin
               rdata_next[1:0] = 2'(src_reg);
               rdata_next[STATUS_PLL_LOCK_BIT] = pll_lock;
            end
            ADDR_IRQ_STAT: rdata_next[1:0] = stat_reg;
            ADDR_IRQ_MASK: rdata_next[1:0] = mask_reg;
            default: rdata_next = '0;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         ctrl_reg <= CTRL_RST;
         presc_reg <= PRESC_RST;
         mask_reg <= MASK_RST;
         stat_reg <= 2'h0;
         rdata_reg <= '0;
         irq_reg <= 1'b0;
      end else begin
         ctrl_reg <= ctrl_next;
         presc_reg <= presc_next;
         mask_reg <= mask_next;
         stat_reg <= stat_next;
         rdata_reg <= rdata_next;
         irq_reg <= irq_next;
      end
   end

   assign reg_rdata = rdata_reg;
   assign irq = irq_reg;
   assign active_src = src_reg;

   a_reset_to_rc: assert property (@(posedge clk_sys)
      !reset_n |=> src_reg == SCSM_SRC_RC)
      else $error("source not internal RC after reset");

   a_ext_selectable: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (wr_ctrl && req_src == SCSM_SRC_EXT && !css_evt && !pll_fail_evt)
      |=> (src_reg == SCSM_SRC_EXT) && mon_en)
      else $error("external source not selected or not watched");

   a_fallback_to_rc: assert property (@(posedge clk_sys) disable iff (!reset_n)
      css_evt |=> (src_reg == SCSM_SRC_RC) && stat_reg[IRQ_CSS_BIT])
      else $error("no fallback after clock failure");

   a_css_irq_gate: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (css_evt && mask_reg[IRQ_CSS_BIT] && mask_next[IRQ_CSS_BIT]) |=> ##1 irq)
      else $error("enabled failure interrupt not raised");

   a_irq_masked: assert property (@(posedge clk_sys) disable iff (!reset_n)
      ($past(mask_reg) == 2'h0) |-> !irq)
      else $error("interrupt raised while disabled");

   a_pll_fail_flag: assert property (@(posedge clk_sys) disable iff (!reset_n)
      pll_fail_evt |=> stat_reg[IRQ_PLL_BIT] && (src_reg == SCSM_SRC_RC))
      else $error("loop failure not flagged");

   a_presc_chain: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (fast_bus_tick || slow_bus_tick) |-> $past(sys_bus_tick))
      else $error("peripheral tick without system tick");

   a_single_root: assert property (@(posedge clk_sys) disable iff (!reset_n)
      sys_bus_tick |-> $past(root_tick_reg))
      else $error("system tick not from root source");

   a_flag_sticky: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (stat_reg[IRQ_CSS_BIT] && !(wr_stat && reg_wdata[IRQ_CSS_BIT]))
      |=> stat_reg[IRQ_CSS_BIT])
      else $error("failure flag lost without clear");

   a_pll_ext_fail: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (css_evt && (src_reg == SCSM_SRC_PLL) && ctrl_reg[CTRL_PLL_EXT_BIT])
      |=> (stat_reg == 2'h3) && (src_reg == SCSM_SRC_RC))
      else $error("indirect external failure not flagged on loop");

   a_pll_lock_loss: assert property (@(posedge clk_sys) disable iff (!reset_n)
      ((src_reg == SCSM_SRC_PLL) && !pll_lock)
      |=> (src_reg == SCSM_SRC_RC) && stat_reg[IRQ_PLL_BIT])
      else $error("loop lock loss not handled");

   a_irq_raise: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (|(stat_reg & mask_reg)) |=> irq)
      else $error("unmasked flag without interrupt");

   a_irq_drop: assert property (@(posedge clk_sys) disable iff (!reset_n)
      !(|(stat_reg & mask_reg)) |=> !irq)
      else $error("interrupt without unmasked flag");

   a_pll_sticky: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (stat_reg[IRQ_PLL_BIT] && !(wr_stat && reg_wdata[IRQ_PLL_BIT]))
      |=> stat_reg[IRQ_PLL_BIT])
      else $error("loop flag lost without clear");

   a_flag_clear: assert property (@(posedge clk_sys) disable iff (!reset_n)
      (wr_stat && reg_wdata[IRQ_CSS_BIT] && !css_evt) |=> !stat_reg[IRQ_CSS_BIT])
      else $error("failure flag not cleared by write");

   a_rc_root: assert property (@(posedge clk_sys) disable iff (!reset_n)
      ((src_reg == SCSM_SRC_RC) && rc_tick_reg) |=> root_tick_reg)
      else $error("internal RC tick not on root");

   a_ext_root: assert property (@(posedge clk_sys) disable iff (!reset_n)
      ((src_reg == SCSM_SRC_EXT) && mon_edge) |=> root_tick_reg)
      else $error("external edge not on root");

   a_pll_root: assert property (@(posedge clk_sys) disable iff (!reset_n)
      ((src_reg == SCSM_SRC_PLL) && pll_clk_tick) |=> root_tick_reg)
      else $error("loop tick not on root");
endmodule : scsm_top
`default_nettype wire

/* tb/scsm_osc_model.sv */
`timescale 1ns/10ps
`default_nettype none
module scsm_osc_model #(
   parameter int HALF_CYC = 3
) (
   input wire logic clk_sys, // system clock
   input wire logic run, // oscillator alive
   output logic ext_clk // oscillator level
);
   int cnt;
   initial begin
      ext_clk = 1'b0;
      cnt = 0;
   end
   // 16.7 MHz, inside the 4-32 MHz band
   // a dead crystal freezes at its last level, so the monitor sees no edge
   always @(posedge clk_sys) begin
      if (run) begin
         if (cnt == HALF_CYC - 1) begin
            cnt <= 0;
            ext_clk <= ~ext_clk;
         end else begin
            cnt <= cnt + 1;
         end
      end
   end
endmodule : scsm_osc_model
`default_nettype wire

/* tb/scsm_top_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module scsm_top_tb_top;
   import scsm_pkg::*;
   logic clk_sys, reset_n, reg_wr, reg_rd, osc_run, ext_clk_in;
   logic pll_clk_tick, pll_lock, irq, sys_bus_tick, fast_bus_tick, slow_bus_tick;
   logic [AW-1:0] reg_addr;
   logic [DW-1:0] reg_wdata, reg_rdata, d;
   scsm_src_t active_src;
   int mismatches = 0;
   int num_checks = 0;

   scsm_top scsm_top_i (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .ext_clk_in(ext_clk_in), .pll_clk_tick(pll_clk_tick), .pll_lock(pll_lock),
      .irq(irq), .active_src(active_src), .sys_bus_tick(sys_bus_tick),
      .fast_bus_tick(fast_bus_tick), .slow_bus_tick(slow_bus_tick));
   scsm_osc_model scsm_osc_model_i (.clk_sys(clk_sys), .run(osc_run), .ext_clk(ext_clk_in));

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   // loop model: one rate pulse every other cycle while locked
   always @(posedge clk_sys) pll_clk_tick <= pll_lock && !pll_clk_tick;

   task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task automatic wr(logic [7:0] a, logic [31:0] v);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(logic [7:0] a);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd

   // bounded wait for the source to change
   task automatic wait_src(scsm_src_t s, int lim);
      for (int i = 0; i < lim && active_src !== s; i++) @(posedge clk_sys);
      #1 chk("active_src", 32'(active_src), 32'(s));
   endtask : wait_src

   task automatic t_reset;
      chk("src_after_reset", 32'(active_src), 32'(SCSM_SRC_RC));
      rd(ADDR_STATUS);
      chk("status_reset", d, 32'h0000_0000);
      rd(ADDR_PRESC);
      chk("presc_reset", d, PRESC_RST);
      rd(ADDR_IRQ_MASK);
      chk("mask_reset", d, 32'h0000_0000);
      rd(8'h14);
      chk("unmapped", d, 32'h0000_0000);
   endtask : t_reset

   task automatic t_ext_fail;
      osc_run <= 1'b0;
      repeat (150) @(posedge clk_sys);
      rd(ADDR_IRQ_STAT);
      chk("unwatched_stat", d, 32'h0000_0000);
      osc_run <= 1'b1;
      wr(ADDR_CTRL, 32'h0000_0001);
      wait_src(SCSM_SRC_EXT, 3);
      repeat (300) @(posedge clk_sys);
      chk("ext_kept", 32'(active_src), 32'(SCSM_SRC_EXT));
      wr(ADDR_IRQ_MASK, 32'h0000_0001);
      osc_run <= 1'b0;
      wait_src(SCSM_SRC_RC, MON_TIMEOUT_CYC + 20);
      rd(ADDR_IRQ_STAT);
      chk("css_stat", d, 32'h0000_0001);
      chk("irq_on", 32'(irq), 32'h1);
      repeat (200) @(posedge clk_sys);
      rd(ADDR_IRQ_STAT);
      chk("css_sticky", d, 32'h0000_0001);
      wr(ADDR_IRQ_STAT, 32'h0000_0001);
      repeat (2) @(posedge clk_sys);
      #1 chk("irq_cleared", 32'(irq), 32'h0);
   endtask : t_ext_fail

   task automatic t_masked_fail;
      wr(ADDR_IRQ_MASK, 32'h0000_0000);
      wr(ADDR_CTRL, 32'h0000_0001);
      wait_src(SCSM_SRC_EXT, 3);
      wait_src(SCSM_SRC_RC, MON_TIMEOUT_CYC + 20);
      repeat (3) @(posedge clk_sys);
      #1 chk("irq_masked", 32'(irq), 32'h0);
      wr(ADDR_IRQ_MASK, 32'h0000_0001);
      repeat (2) @(posedge clk_sys);
      #1 chk("irq_unmasked", 32'(irq), 32'h1);
      wr(ADDR_IRQ_STAT, 32'h0000_0001);
   endtask : t_masked_fail

   task automatic t_pll_fail;
      pll_lock <= 1'b1;
      wr(ADDR_IRQ_MASK, 32'h0000_0002);
      wr(ADDR_CTRL, 32'h0000_0002);
      wait_src(SCSM_SRC_PLL, 3);
      rd(ADDR_STATUS);
      chk("status_pll", d, 32'h0000_0006);
      @(posedge clk_sys);
      pll_lock <= 1'b0;
      wait_src(SCSM_SRC_RC, 4);
      rd(ADDR_IRQ_STAT);
      chk("pll_stat", d, 32'h0000_0002);
      chk("pll_irq", 32'(irq), 32'h1);
      wr(ADDR_IRQ_STAT, 32'h0000_0002);
   endtask : t_pll_fail

   // loop fed from the dead external oscillator: watched, both flags
   task automatic t_pll_ext;
      int ns;
      ns = 0;
      pll_lock <= 1'b1;
      wr(ADDR_IRQ_MASK, 32'h0000_0003);
      wr(ADDR_CTRL, 32'h0000_0006);
      wait_src(SCSM_SRC_PLL, 3);
      repeat (40) begin
         @(posedge clk_sys);
         #1;
         ns += int'(sys_bus_tick === 1'b1);
      end
      chk("pll_sys_ticks", 32'(ns >= 19 && ns <= 21), 32'h1);
      rd(ADDR_CTRL);
      chk("ctrl_pll_ext", d, 32'h0000_0006);
      wait_src(SCSM_SRC_RC, MON_TIMEOUT_CYC + 20);
      rd(ADDR_IRQ_STAT);
      chk("pll_ext_stat", d, 32'h0000_0003);
      chk("pll_ext_irq", 32'(irq), 32'h1);
      wr(ADDR_IRQ_STAT, 32'h0000_0003);
   endtask : t_pll_ext

   task automatic t_presc;
      int ns, nf, nl;
      ns = 0;
      nf = 0;
      nl = 0;
      // sys /1, fast /2, slow /4 of a 100/12 MHz root stays under the ceilings
      wr(ADDR_PRESC, 32'h0000_0310);
      repeat (50) @(posedge clk_sys);
      repeat (RC_DIV_CYC * 100) begin
         @(posedge clk_sys);
         #1;
         ns += int'(sys_bus_tick === 1'b1);
         nf += int'(fast_bus_tick === 1'b1);
         nl += int'(slow_bus_tick === 1'b1);
      end
      chk("sys_ticks", 32'(ns >= 99 && ns <= 101), 32'h1);
      chk("fast_ticks", 32'(nf >= 49 && nf <= 51), 32'h1);
      chk("slow_ticks", 32'(nl >= 24 && nl <= 26), 32'h1);
   endtask : t_presc

   // second reset while the external source is selected
   task automatic t_reset_mid;
      wr(ADDR_CTRL, 32'h0000_0001);
      wait_src(SCSM_SRC_EXT, 3);
      @(posedge clk_sys);
      reset_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      reset_n <= 1'b1;
      @(posedge clk_sys);
      #1 chk("src_mid_reset", 32'(active_src), 32'(SCSM_SRC_RC));
      rd(ADDR_PRESC);
      chk("presc_mid_reset", d, PRESC_RST);
      rd(ADDR_CTRL);
      chk("ctrl_mid_reset", d, CTRL_RST);
   endtask : t_reset_mid

   task automatic conclude;
      if (mismatches == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : conclude

   initial begin
      #60000;
      mismatches++;
      conclude();
   end

   initial begin
      reset_n = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = '0;
      reg_wdata = '0;
      osc_run = 1'b1;
      pll_lock = 1'b0;
      repeat (6) @(posedge clk_sys);
      reset_n <= 1'b1;
      @(posedge clk_sys);
      #1;
      t_reset();
      t_ext_fail();
      t_masked_fail();
      t_pll_fail();
      t_pll_ext();
      t_presc();
      t_reset_mid();
      conclude();
   end
endmodule : scsm_top_tb_top
`default_nettype wire
